//--- echo_cfg_pkg.sv
// constants, field layouts and carrier types for the echo / drive configuration slice
// assumes: an axi4-lite master and the analog / burst logic around it
package echo_cfg_pkg;
  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] idx_echo_threshold_config = 8'h17;
  localparam logic [7:0] idx_zero_cross_config = 8'h18;
  localparam logic [7:0] idx_drive_current_limit = 8'h19;
  localparam logic [7:0] idx_burst_setup = 8'h1A;
  localparam logic [7:0] idx_event_status = 8'h20;
  localparam logic [7:0] idx_event_mask = 8'h21;
  localparam logic [7:0] idx_burst_control = 8'h22;
  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] rst_echo_threshold_config = 8'h07;
  localparam logic [7:0] rst_zero_cross_config = 8'h14;
  localparam logic [7:0] rst_drive_current_limit = 8'h00;
  localparam logic [7:0] rst_burst_setup = 8'h00;
  localparam logic [7:0] wmask_echo_threshold_config = 8'h1F;
  localparam logic [7:0] wmask_zero_cross_config = 8'hFF;
  localparam logic [7:0] wmask_drive_current_limit = 8'h3F;
  localparam logic [7:0] wmask_burst_setup = 8'hFF;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int pos_echo_cmp_enable = 4;
  localparam int pos_zc_enable = 7;
  localparam int pos_zc_gate = 6;
  localparam int pos_zc_input = 5;
  localparam int pos_half_bridge = 7;
  localparam int pos_fault_status = 0;
  localparam int pos_burst_start = 0;
  // ----------------------------------------
  // analog scaling, in millivolts and microamps
  // ----------------------------------------
  localparam int thr_low_step_mv = 40;
  localparam int thr_low_base_mv = 400;
  localparam int thr_high_step_mv = 60;
  localparam int thr_high_base_mv = 600;
  localparam int hyst_base_mv = 30;
  localparam int hyst_step_mv = 50;
  localparam int clamp_base_ua = 50000;
  localparam int clamp_step_ua = 7140;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;
  typedef struct packed {
    logic enable;
    logic gate_on_detect;
    logic input_select;
    logic [1:0] stage_select;
    logic [2:0] hysteresis;
  } zero_cross_cfg_t;
  typedef struct packed {
    logic half_bridge_enable;
    logic [5:0] pulse_count;
  } burst_cfg_t;
  typedef enum logic [1:0] {
    burst_idle = 2'b00,
    burst_run = 2'b01,
    burst_check = 2'b11
  } burst_state_t;
endpackage

//--- threshold_map.sv
// ----------------------------------------
// threshold and analog-trim code-to-level mapping
// ----------------------------------------
// assumes codes come from registers on the same clock
`timescale 1ns/10ps
module threshold_map
  import echo_cfg_pkg::*;
(
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  // codes
  input wire logic [3:0] threshold_code,
  input wire logic scale_select,
  input wire logic [2:0] hyst_code,
  input wire logic [5:0] clamp_code,
  // levels
  output logic [11:0] threshold_mv,
  output logic [9:0] hysteresis_mv,
  output logic [19:0] clamp_ua
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_mv <= 12'h000;
    end else if (scale_select) begin
      threshold_mv <= 12'(thr_high_step_mv * threshold_code + thr_high_base_mv);
    end else begin
      threshold_mv <= 12'(thr_low_step_mv * threshold_code + thr_low_base_mv);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hysteresis_mv <= 10'h000;
      clamp_ua <= 20'h00000;
    end else begin
      hysteresis_mv <= 10'(hyst_base_mv + hyst_step_mv * hyst_code);
      clamp_ua <= 20'(clamp_base_ua + clamp_step_ua * clamp_code);
    end
  end
endmodule

//--- pulse_checker.sv
// ----------------------------------------
// burst pulse counter and pulse-count fault detector
// ----------------------------------------
// assumes pulse_seen is a synchronised one-cycle pulse per driver pulse
`timescale 1ns/10ps
module pulse_checker
  import echo_cfg_pkg::*;
(
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic burst_active,
  input wire logic [5:0] pulse_count,
  input wire logic pulse_seen,
  // result
  output logic fault_pulse,
  output logic burst_done
);
  burst_state_t state_r;
  logic [5:0] count_r;
  logic ended_r;
  // a burst that reached its count stays finished until software drops the start bit,
  // otherwise a still-set start bit would rearm a fresh burst and fault it on release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ended_r <= 1'b0;
    end else if (!burst_active) begin
      ended_r <= 1'b0;
    end else if (burst_done) begin
      ended_r <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= burst_idle;
      count_r <= 6'h00;
      fault_pulse <= 1'b0;
      burst_done <= 1'b0;
    end else begin
      fault_pulse <= 1'b0;
      burst_done <= 1'b0;
      case (state_r)
        burst_idle: begin
          count_r <= 6'h00;
          if (burst_active && !ended_r) begin
            state_r <= burst_run;
          end
        end
        burst_run: begin
          if (pulse_seen && count_r != 6'h3F) begin
            count_r <= count_r + 6'h01;
          end
          // zero count never finishes on its own
          if (pulse_count != 6'h00 && pulse_seen && count_r + 6'h01 == pulse_count) begin
            burst_done <= 1'b1;
            state_r <= burst_check;
          end else if (!burst_active) begin
            state_r <= burst_check;
          end
        end
        burst_check: begin
          fault_pulse <= (pulse_count != 6'h00) && (count_r < pulse_count);
          state_r <= burst_idle;
        end
        default: state_r <= burst_idle;
      endcase
    end
  end
endmodule

//--- echo_drive_config_regs.sv
// ----------------------------------------
// echo / zero-cross / drive / burst configuration registers on axi4-lite
// ----------------------------------------
// assumes comparator and pulse inputs arrive asynchronously from the analog side
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module echo_drive_config_regs
  import echo_cfg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparators
  input wire logic echo_cmp_raw,
  input wire logic zero_cross_raw,
  input wire logic drive_pulse_raw,
  // pins and analog controls
  output logic threshold_event_pin,
  output logic zero_cross_out,
  output logic [11:0] threshold_mv,
  output logic output_scale_select,
  output zero_cross_cfg_t zc_cfg,
  output logic [9:0] hysteresis_mv,
  output logic [19:0] clamp_ua,
  output burst_cfg_t burst_cfg,
  output logic burst_active,
  output logic pulse_count_fault,
  output logic irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] echo_r;
  logic [7:0] zc_r;
  logic [7:0] clamp_r;
  logic [7:0] burst_r;
  logic [7:0] control_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [9:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r;
  logic w_held_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic pulse_prev_r;
  logic fault_pulse;
  logic do_write;
  logic [7:0] wr_idx;
  logic [7:0] wbyte;
  logic [7:0] rd_idx;
  logic rd_fire;
  logic status_read;
  // ----------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r;
  assign wr_idx = awaddr_r[9:2];
  assign wbyte = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (wr_idx)
        idx_echo_threshold_config, idx_zero_cross_config, idx_drive_current_limit,
        idx_burst_setup, idx_event_status, idx_event_mask, idx_burst_control: s_axi_bresp <= axi_okay;
        default: s_axi_bresp <= axi_slverr;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // only byte lane 0 carries data; a write without it stores nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      echo_r <= rst_echo_threshold_config;
      zc_r <= rst_zero_cross_config;
      clamp_r <= rst_drive_current_limit;
      burst_r <= rst_burst_setup;
      mask_r <= 8'h00;
      control_r <= 8'h00;
    end else if (do_write && wstrb_r[0]) begin
      case (wr_idx)
        idx_echo_threshold_config: echo_r <= wbyte & wmask_echo_threshold_config;
        idx_zero_cross_config: zc_r <= wbyte & wmask_zero_cross_config;
        idx_drive_current_limit: clamp_r <= wbyte & wmask_drive_current_limit;
        idx_burst_setup: burst_r <= wbyte & wmask_burst_setup;
        idx_event_mask: mask_r <= wbyte & 8'h01;
        idx_burst_control: control_r <= wbyte & 8'h03;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // read channel: one cycle to rvalid
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[9:2];
  assign status_read = rd_fire && rd_idx == idx_event_status;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= axi_okay;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= axi_okay;
      case (rd_idx)
        idx_echo_threshold_config: s_axi_rdata <= {24'h000000, echo_r};
        idx_zero_cross_config: s_axi_rdata <= {24'h000000, zc_r};
        idx_drive_current_limit: s_axi_rdata <= {24'h000000, clamp_r};
        idx_burst_setup: s_axi_rdata <= {24'h000000, burst_r};
        idx_event_status: s_axi_rdata <= {24'h000000, status_r};
        idx_event_mask: s_axi_rdata <= {24'h000000, mask_r};
        idx_burst_control: s_axi_rdata <= {24'h000000, control_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= axi_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      pulse_prev_r <= 1'b0;
    end else begin
      sync1_r <= {drive_pulse_raw, zero_cross_raw, echo_cmp_raw};
      sync2_r <= sync1_r;
      pulse_prev_r <= sync2_r[2];
    end
  end
  // ----------------------------------------
  // comparator outputs and configuration fan-out
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_event_pin <= 1'b0;
      zero_cross_out <= 1'b0;
    end else begin
      threshold_event_pin <= echo_r[pos_echo_cmp_enable] & sync2_r[0];
      // gating uses the raw detect, so it works even with the pin disabled
      zero_cross_out <= zc_r[pos_zc_enable] & sync2_r[1] & (!zc_r[pos_zc_gate] | sync2_r[0]);
    end
  end
  assign output_scale_select = control_r[1];
  assign zc_cfg.enable = zc_r[pos_zc_enable];
  assign zc_cfg.gate_on_detect = zc_r[pos_zc_gate];
  assign zc_cfg.input_select = zc_r[pos_zc_input];
  assign zc_cfg.stage_select = zc_r[4:3];
  assign zc_cfg.hysteresis = zc_r[2:0];
  assign burst_cfg.half_bridge_enable = burst_r[pos_half_bridge];
  assign burst_cfg.pulse_count = burst_r[5:0];
  assign burst_active = control_r[pos_burst_start];
  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 8'h00;
      pulse_count_fault <= 1'b0;
    end else begin
      // set wins over the clear-on-read in the same cycle
      if (fault_pulse) begin
        status_r[pos_fault_status] <= 1'b1;
      end else if (status_read) begin
        status_r[pos_fault_status] <= 1'b0;
      end
      if (fault_pulse) begin
        pulse_count_fault <= 1'b1;
      end else if (status_read) begin
        pulse_count_fault <= 1'b0;
      end
    end
  end
  assign irq = |(status_r & mask_r);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  threshold_map u_map (
    .aclk(aclk),
    .aresetn(aresetn),
    .threshold_code(echo_r[3:0]),
    .scale_select(output_scale_select),
    .hyst_code(zc_r[2:0]),
    .clamp_code(clamp_r[5:0]),
    .threshold_mv(threshold_mv),
    .hysteresis_mv(hysteresis_mv),
    .clamp_ua(clamp_ua)
  );
  pulse_checker u_check (
    .aclk(aclk),
    .aresetn(aresetn),
    .burst_active(burst_active),
    .pulse_count(burst_r[5:0]),
    .pulse_seen(sync2_r[2] & !pulse_prev_r),
    .fault_pulse(fault_pulse),
    .burst_done()
  );
endmodule

//--- echo_drive_config_regs_sva.sv
// concurrent checks on the echo / drive configuration slice
// assumes: bound to echo_drive_config_regs, one clock, sync low reset
`timescale 1ns/10ps
module echo_drive_config_regs_sva
  import echo_cfg_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // observed
  input wire logic echo_cmp_raw,
  input wire logic threshold_event_pin,
  input wire logic zero_cross_out,
  input wire logic [11:0] threshold_mv,
  input wire logic output_scale_select,
  input wire zero_cross_cfg_t zc_cfg,
  input wire logic [9:0] hysteresis_mv,
  input wire logic [19:0] clamp_ua,
  input wire burst_cfg_t burst_cfg,
  input wire logic pulse_count_fault,
  input wire logic irq,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // four quiet samples cover the two-flop synchroniser plus the output flop
  sequence s_echo_quiet;
    !echo_cmp_raw [*4];
  endsequence
  sequence s_gate_closed;
    (zc_cfg.gate_on_detect && !echo_cmp_raw) [*4];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_event_quiet: assert property (s_echo_quiet |=> !threshold_event_pin)
    else $error("event pin high without comparator");
  a_zc_disabled: assert property (!zc_cfg.enable |=> !zero_cross_out)
    else $error("zero-cross output while disabled");
  a_zc_gated: assert property (s_gate_closed |=> !zero_cross_out)
    else $error("zero-cross output passed while gated");
  a_hyst_map: assert property ($past(aresetn) && $stable(zc_cfg.hysteresis) |->
    hysteresis_mv == 10'(hyst_base_mv + hyst_step_mv * zc_cfg.hysteresis))
    else $error("hysteresis level wrong");
  a_thr_form: assert property ($past(aresetn) && $stable(output_scale_select) |-> (output_scale_select ?
    (threshold_mv >= 600 && threshold_mv <= 1500 && (threshold_mv - 12'd600) % 60 == 0) :
    (threshold_mv >= 400 && threshold_mv <= 1000 && (threshold_mv - 12'd400) % 40 == 0)))
    else $error("threshold level off the scale");
  a_clamp_form: assert property ($past(aresetn) |-> clamp_ua >= 20'd50000 && clamp_ua <= 20'd499820
    && (clamp_ua - 20'd50000) % 7140 == 0)
    else $error("clamp level off the scale");
  a_fault_count: assert property ($rose(pulse_count_fault) |-> burst_cfg.pulse_count != 6'h00)
    else $error("fault raised in continuous burst");
  a_irq_source: assert property (irq |-> pulse_count_fault)
    else $error("interrupt without status");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule

bind echo_drive_config_regs echo_drive_config_regs_sva i_sva (.aclk(aclk), .aresetn(aresetn),
  .echo_cmp_raw(echo_cmp_raw), .threshold_event_pin(threshold_event_pin), .zero_cross_out(zero_cross_out),
  .threshold_mv(threshold_mv), .output_scale_select(output_scale_select), .zc_cfg(zc_cfg),
  .hysteresis_mv(hysteresis_mv), .clamp_ua(clamp_ua), .burst_cfg(burst_cfg),
  .pulse_count_fault(pulse_count_fault), .irq(irq), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid));

//--- echo_drive_config_regs_tb.sv
// self-checking bench for the echo / drive configuration slice
// assumes: the bench is the only axi4-lite master, bready and rready held high
`timescale 1ns/10ps
module echo_drive_config_regs_tb
  import echo_cfg_pkg::*;
;
  logic aclk, aresetn;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic echo_cmp_raw, zero_cross_raw, drive_pulse_raw, threshold_event_pin, zero_cross_out;
  logic output_scale_select, burst_active, pulse_count_fault, irq;
  logic [11:0] threshold_mv;
  logic [9:0] hysteresis_mv;
  logic [19:0] clamp_ua;
  zero_cross_cfg_t zc_cfg;
  burst_cfg_t burst_cfg;
  logic [7:0] d, idx;
  logic [7:0] wm [4] = '{wmask_echo_threshold_config, wmask_zero_cross_config,
    wmask_drive_current_limit, wmask_burst_setup};
  int miscompares, cmp_count, seed;

  echo_drive_config_regs i_echo_drive_config_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .echo_cmp_raw(echo_cmp_raw),
    .zero_cross_raw(zero_cross_raw), .drive_pulse_raw(drive_pulse_raw),
    .threshold_event_pin(threshold_event_pin), .zero_cross_out(zero_cross_out),
    .threshold_mv(threshold_mv), .output_scale_select(output_scale_select), .zc_cfg(zc_cfg),
    .hysteresis_mv(hysteresis_mv), .clamp_ua(clamp_ua), .burst_cfg(burst_cfg),
    .burst_active(burst_active), .pulse_count_fault(pulse_count_fault), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task final_report;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    miscompares++;
    $display("Error %0t handshake timeout", $time);
    final_report;
  endtask

  function logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  // upper data bits are random noise the slave must ignore
  task wr(input logic [7:0] i, input logic [7:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= ba(i);
    s_axi_wdata <= {24'($random(seed)), v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) hang;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask

  task rdr(input logic [7:0] i);
    int n;
    n = 0;
    s_axi_araddr <= ba(i);
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) hang;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  function logic [31:0] thr(input logic [3:0] c, input logic s);
    return s ? thr_high_step_mv * c + thr_high_base_mv : thr_low_step_mv * c + thr_low_base_mv;
  endfunction

  task burst(input logic [5:0] cnt, input int np, input logic m);
    logic e;
    e = cnt != 6'h00 && np < cnt;
    wr(idx_event_mask, {7'h0, m});
    wr(idx_burst_setup, {2'b00, cnt});
    wr(idx_burst_control, 8'h01);
    chk(burst_active, 1'b1);
    repeat (np) begin
      drive_pulse_raw <= 1'b1;
      repeat (3) @(posedge aclk);
      drive_pulse_raw <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    wr(idx_burst_control, 8'h00);
    repeat (8) @(posedge aclk);
    chk(pulse_count_fault, e);
    chk(irq, e & m);
    rdr(idx_event_status);
    chk(rd, {31'h0, e});
    @(posedge aclk);
    chk(irq, 1'b0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hd92a;
    miscompares = 0;
    cmp_count = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {echo_cmp_raw, zero_cross_raw, drive_pulse_raw} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(idx_echo_threshold_config);
    chk(rd, 32'h07);
    rdr(idx_zero_cross_config);
    chk(rd, 32'h14);
    rdr(idx_drive_current_limit);
    chk(rd, 32'h00);
    rdr(idx_burst_setup);
    chk(rd, 32'h00);
    chk(threshold_mv, 680);
    chk(hysteresis_mv, 230);
    chk(clamp_ua, 50000);
    for (int i = 0; i < 28; i++) begin
      d = (i < 4) ? 8'h00 : (i < 8) ? 8'hFF : 8'($random(seed));
      idx = idx_echo_threshold_config + 8'(i % 4);
      wr(idx, d);
      chk(resp, axi_okay);
      rdr(idx);
      chk(rd, {24'h0, d & wm[i % 4]});
      wr(idx_burst_control, {6'h0, d[0], 1'b0});
      repeat (3) @(posedge aclk);
      chk({burst_active, output_scale_select}, {1'b0, d[0]});
      case (i % 4)
        0: chk(threshold_mv, thr(d[3:0], d[0]));
        1: chk(zc_cfg, d);
        2: chk(clamp_ua, clamp_base_ua + clamp_step_ua * d[5:0]);
        default: chk(burst_cfg, {d[7], d[5:0]});
      endcase
      if (i % 4 == 1) chk(hysteresis_mv, hyst_base_mv + hyst_step_mv * d[2:0]);
    end
    wr(8'hFF, 8'hA5);
    chk(resp, axi_slverr);
    rdr(8'hFF);
    chk(rd, 32'h0);
    chk(resp, axi_slverr);
    // comparator routing with the enables off, then on
    wr(idx_echo_threshold_config, 8'h07);
    wr(idx_zero_cross_config, 8'h14);
    echo_cmp_raw <= 1'b1;
    zero_cross_raw <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({threshold_event_pin, zero_cross_out}, 2'b00);
    wr(idx_echo_threshold_config, 8'h17);
    wr(idx_zero_cross_config, 8'hD4);
    repeat (6) @(posedge aclk);
    chk({threshold_event_pin, zero_cross_out}, 2'b11);
    echo_cmp_raw <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({threshold_event_pin, zero_cross_out}, 2'b00);
    wr(idx_zero_cross_config, 8'h94);
    repeat (6) @(posedge aclk);
    chk(zero_cross_out, 1'b1);
    burst(6'd3, 2, 1'b1);
    burst(6'd3, 2, 1'b0);
    burst(6'd3, 3, 1'b1);
    burst(6'd0, 4, 1'b1);
    burst(6'd1, 0, 1'b1);
    final_report;
  end
endmodule
